// ==== hw/ata_card_dev.sv ====
// Card end: erase, diagnostic, cache flush and format-track command logic
// ************************************************************
// ************************************************************
`timescale 1ns/100ps
module ata_card_dev #(
    parameter bit FLUSH_SUPPORTED = 1'b1,
    parameter int SECTORS_PER_TRACK = ata_pkg::SECT_PER_TRACK,
    parameter int DRQ_MAX_CYCLES = ata_pkg::DRQ_MAX_CYC,
    parameter int PREP_CYCLES = ata_pkg::PREP_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    ata_link_if.dev link,
    input wire logic fixed_disk_mode,
    input wire logic own_drive,
    input wire logic secondary_fail,
    output logic diag_req,
    input wire logic diag_done,
    input wire logic [7:0] diag_code,
    output logic media_req,
    output ata_pkg::media_op_e media_op,
    output logic [27:0] media_lba,
    output logic [7:0] media_pattern,
    input wire logic media_ack,
    input wire logic media_fault
);
    typedef enum logic [2:0]
    {
        S_IDLE = 3'b000,
        S_MEDIA = 3'b001,
        S_DIAG = 3'b010,
        S_PREP = 3'b011,
        S_DATA = 3'b100,
        S_DONE = 3'b101
    } state_e;

    state_e state_q;
    logic [7:0] scnt_q, snum_q, cyllo_q, cylhi_q, drvhd_q, status_q, error_q, rdata_q;
    logic [8:0] remain_q;
    logic [8:0] words_q;
    logic fault_q, abort_q, intrq_q, diag_req_q, media_req_q;
    ata_pkg::media_op_e op_q;
    logic [27:0] lba_q;
    logic [7:0] diag_res_q;
    logic cmd_wr, sel_ok, prep_done, last_sect;
    logic [8:0] cnt_ext;

    // Task-file writes are refused while busy; the host must poll first
    assign cmd_wr = link.wr && link.addr == ata_pkg::TF_STATCMD && !status_q[ata_pkg::ST_BSY];
    assign sel_ok = fixed_disk_mode || (drvhd_q[ata_pkg::DH_DRV] == own_drive);
    assign cnt_ext = (scnt_q == 8'h00) ? 9'h100 : {1'b0, scnt_q};
    assign last_sect = (remain_q == 9'h001);

    // Prep time is far below the DRQ limit, so DRQ always rises in time
    cycle_timer #(.W(18)) prep_timer (
        .pclk(pclk),
        .presetn(presetn),
        .load(cmd_wr && link.wdata[7:0] == ata_pkg::CMD_FORMAT && sel_ok),
        .value(18'(PREP_CYCLES)),
        .done(prep_done)
    );

    // ************************************************************
    // Task-file registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scnt_q <= 8'h01;
            snum_q <= 8'h01;
            cyllo_q <= 8'h00;
            cylhi_q <= 8'h00;
            drvhd_q <= 8'h00;
        end
        else if (link.wr && !status_q[ata_pkg::ST_BSY] && state_q == S_IDLE)
        begin
            case (link.addr)
                ata_pkg::TF_SCNT: scnt_q <= link.wdata[7:0];
                ata_pkg::TF_SNUM: snum_q <= link.wdata[7:0];
                ata_pkg::TF_CYLLO: cyllo_q <= link.wdata[7:0];
                ata_pkg::TF_CYLHI: cylhi_q <= link.wdata[7:0];
                ata_pkg::TF_DRVHD: drvhd_q <= link.wdata[7:0];
                default: ;
            endcase
        end
    end

    // ************************************************************
    // Command sequencer
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= S_IDLE;
            status_q <= ata_pkg::STATUS_RST;
            error_q <= ata_pkg::ERROR_RST;
            remain_q <= 9'h000;
            words_q <= 9'h000;
            lba_q <= 28'h0000000;
            op_q <= ata_pkg::OP_NONE;
            fault_q <= 1'b0;
            abort_q <= 1'b0;
            diag_req_q <= 1'b0;
            media_req_q <= 1'b0;
            diag_res_q <= 8'h00;
        end
        else
        begin
            case (state_q)
                S_IDLE:
                begin
                    if (cmd_wr && sel_ok)
                    begin
                        // Busy rises at the very next edge, well inside the limit
                        status_q[ata_pkg::ST_BSY] <= 1'b1;
                        status_q[ata_pkg::ST_ERR] <= 1'b0;
                        status_q[ata_pkg::ST_DF] <= 1'b0;
                        fault_q <= 1'b0;
                        abort_q <= 1'b0;
                        case (link.wdata[7:0])
                            ata_pkg::CMD_ERASE:
                            begin
                                lba_q <= {drvhd_q[3:0], cylhi_q, cyllo_q, snum_q};
                                remain_q <= cnt_ext;
                                op_q <= ata_pkg::OP_ERASE;
                                media_req_q <= 1'b1;
                                state_q <= S_MEDIA;
                            end
                            ata_pkg::CMD_DIAG:
                            begin
                                diag_req_q <= 1'b1;
                                state_q <= S_DIAG;
                            end
                            ata_pkg::CMD_FLUSH:
                            begin
                                if (FLUSH_SUPPORTED)
                                begin
                                    remain_q <= 9'h001;
                                    op_q <= ata_pkg::OP_FLUSH;
                                    media_req_q <= 1'b1;
                                    state_q <= S_MEDIA;
                                end
                                else
                                begin
                                    abort_q <= 1'b1;
                                    state_q <= S_DONE;
                                end
                            end
                            ata_pkg::CMD_FORMAT:
                            begin
                                lba_q <= {drvhd_q[3:0], cylhi_q, cyllo_q, 8'h00};
                                remain_q <= drvhd_q[ata_pkg::DH_LBA] ? cnt_ext : 9'(SECTORS_PER_TRACK);
                                op_q <= ata_pkg::OP_FILL;
                                state_q <= S_PREP;
                            end
                            default:
                            begin
                                abort_q <= 1'b1;
                                state_q <= S_DONE;
                            end
                        endcase
                    end
                end
                S_PREP:
                begin
                    if (prep_done)
                    begin
                        // DRQ and busy release in the same edge
                        status_q[ata_pkg::ST_DRQ] <= 1'b1;
                        status_q[ata_pkg::ST_BSY] <= 1'b0;
                        words_q <= 9'h000;
                        state_q <= S_DATA;
                    end
                end
                S_DATA:
                begin
                    // Words are counted and thrown away
                    if (link.wr && link.addr == ata_pkg::TF_DATA)
                    begin
                        words_q <= words_q + 9'h001;
                        if (words_q == 9'(ata_pkg::SECTOR_WORDS - 1))
                        begin
                            status_q[ata_pkg::ST_DRQ] <= 1'b0;
                            status_q[ata_pkg::ST_BSY] <= 1'b1;
                            media_req_q <= 1'b1;
                            state_q <= S_MEDIA;
                        end
                    end
                end
                S_MEDIA:
                begin
                    // One acknowledge retires one sector; req stays high between them
                    if (media_ack)
                    begin
                        fault_q <= fault_q | media_fault;
                        lba_q <= lba_q + 28'h0000001;
                        remain_q <= remain_q - 9'h001;
                        if (last_sect)
                        begin
                            media_req_q <= 1'b0;
                            state_q <= S_DONE;
                        end
                    end
                end
                S_DIAG:
                begin
                    diag_req_q <= 1'b0;
                    if (diag_done)
                    begin
                        if (fixed_disk_mode && !own_drive && secondary_fail)
                            diag_res_q <= diag_code | ata_pkg::DIAG_SLAVE;
                        else
                            diag_res_q <= diag_code;
                        op_q <= ata_pkg::OP_NONE;
                        state_q <= S_DONE;
                    end
                end
                S_DONE:
                begin
                    status_q[ata_pkg::ST_BSY] <= 1'b0;
                    status_q[ata_pkg::ST_RDY] <= 1'b1;
                    status_q[ata_pkg::ST_DSC] <= 1'b1;
                    status_q[ata_pkg::ST_DF] <= fault_q;
                    if (abort_q)
                    begin
                        error_q <= ata_pkg::ERR_ABRT;
                        status_q[ata_pkg::ST_ERR] <= 1'b1;
                    end
                    else if (op_q == ata_pkg::OP_NONE)
                    begin
                        error_q <= diag_res_q;
                        status_q[ata_pkg::ST_ERR] <= (diag_res_q != ata_pkg::DIAG_OK);
                    end
                    else
                    begin
                        error_q <= 8'h00;
                        status_q[ata_pkg::ST_ERR] <= fault_q;
                    end
                    op_q <= ata_pkg::OP_NONE;
                    state_q <= S_IDLE;
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Read port and interrupt
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rdata_q <= 8'h00;
        else if (link.rd)
        begin
            case (link.addr)
                ata_pkg::TF_ERRFEAT: rdata_q <= error_q;
                ata_pkg::TF_SCNT: rdata_q <= scnt_q;
                ata_pkg::TF_SNUM: rdata_q <= snum_q;
                ata_pkg::TF_CYLLO: rdata_q <= cyllo_q;
                ata_pkg::TF_CYLHI: rdata_q <= cylhi_q;
                ata_pkg::TF_DRVHD: rdata_q <= drvhd_q;
                ata_pkg::TF_STATCMD: rdata_q <= status_q;
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    // Status read clears the request, but a completion in that cycle wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            intrq_q <= 1'b0;
        else if (state_q == S_DONE || (state_q == S_PREP && prep_done))
            intrq_q <= 1'b1;
        else if (link.rd && link.addr == ata_pkg::TF_STATCMD)
            intrq_q <= 1'b0;
    end

    assign link.rdata = {8'h00, rdata_q};
    assign link.intrq = intrq_q;
    assign diag_req = diag_req_q;
    assign media_req = media_req_q;
    assign media_op = op_q;
    assign media_lba = lba_q;
    assign media_pattern = ata_pkg::FILL_PATTERN;
endmodule

// ==== inc/ata_pkg.sv ====
// Shared constants for the task-file command logic and its host controller
package ata_pkg;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_NS = 5;
    localparam int BSY_MAX_NS = 400;
    localparam int BSY_MAX_CYC = BSY_MAX_NS / CLK_NS;
    localparam int DRQ_MAX_US = 700;
    localparam int DRQ_MAX_CYC = DRQ_MAX_US * 1000 / CLK_NS;
    localparam int PREP_CYC = 16;
    localparam int SECTOR_WORDS = 256;
    localparam int SECT_PER_TRACK = 32;
    // ************************************************************
    // Task file
    // ************************************************************
    localparam logic [2:0] TF_DATA = 3'h0;
    localparam logic [2:0] TF_ERRFEAT = 3'h1;
    localparam logic [2:0] TF_SCNT = 3'h2;
    localparam logic [2:0] TF_SNUM = 3'h3;
    localparam logic [2:0] TF_CYLLO = 3'h4;
    localparam logic [2:0] TF_CYLHI = 3'h5;
    localparam logic [2:0] TF_DRVHD = 3'h6;
    localparam logic [2:0] TF_STATCMD = 3'h7;
    localparam logic [7:0] CMD_ERASE = 8'hc0;
    localparam logic [7:0] CMD_DIAG = 8'h90;
    localparam logic [7:0] CMD_FLUSH = 8'he7;
    localparam logic [7:0] CMD_FORMAT = 8'h50;
    localparam int ST_BSY = 7;
    localparam int ST_RDY = 6;
    localparam int ST_DF = 5;
    localparam int ST_DSC = 4;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    localparam int DH_LBA = 6;
    localparam int DH_DRV = 4;
    localparam logic [7:0] ERR_ABRT = 8'h04;
    localparam logic [7:0] DIAG_OK = 8'h01;
    localparam logic [7:0] DIAG_SLAVE = 8'h80;
    localparam logic [7:0] FILL_PATTERN = 8'hff;
    localparam logic [7:0] STATUS_RST = 8'h50;
    localparam logic [7:0] ERROR_RST = 8'h01;
    typedef enum logic [1:0] {OP_NONE = 2'b00, OP_ERASE = 2'b01, OP_FLUSH = 2'b10, OP_FILL = 2'b11} media_op_e;
    // ************************************************************
    // Host controller APB map
    // ************************************************************
    localparam logic [7:0] REG_REQ = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_FILL = 8'h08;
    localparam int REQ_ADDR_LSB = 16;
    localparam int REQ_RD_BIT = 20;
endpackage

// ==== inc/ata_link_if.sv ====
// Task-file link between the host controller and the card
`timescale 1ns/100ps
interface ata_link_if;
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic intrq;
    modport dev (input wr, input rd, input addr, input wdata, output rdata, output intrq);
    modport host (output wr, output rd, output addr, output wdata, input rdata, input intrq);
endinterface

// ==== hw/cycle_timer.sv ====
// Load-and-count-down timer with a done pulse
`timescale 1ns/100ps
module cycle_timer #(
    parameter int W = 18
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [W-1:0] value,
    output logic done
);
    logic [W-1:0] cnt_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= '0;
        else if (load)
            cnt_q <= value;
        else if (cnt_q != '0)
            cnt_q <= cnt_q - 1'b1;
    end

    assign done = (cnt_q == {{(W-1){1'b0}}, 1'b1});
endmodule

// ==== hw/ata_host_ctrl.sv ====
// Host end: APB-programmed task-file master
`timescale 1ns/100ps
module ata_host_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    ata_link_if.host link
);
    typedef enum logic [2:0]
    {
        H_IDLE = 3'b000,
        H_POLL = 3'b001,
        H_CHK = 3'b010,
        H_ISSUE = 3'b011,
        H_RDWAIT = 3'b100,
        H_FILL = 3'b101
    } hstate_e;

    hstate_e state_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic [15:0] req_data_q, fill_q, last_q, cnt_q;
    logic [2:0] req_addr_q;
    logic req_rd_q, fmt_q, wr_q, rd_q;
    logic [2:0] addr_q;
    logic [15:0] wdata_q;
    logic apb_wr, cmd_ok;

    assign apb_wr = psel && penable && pready_q && pwrite;
    // Commands wait for busy clear; format also waits for DRQ
    assign cmd_ok = fmt_q ? link.rdata[ata_pkg::ST_DRQ] : !link.rdata[ata_pkg::ST_BSY];

    // ************************************************************
    // APB slave: answer in the second access cycle
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end
        else
        begin
            pready_q <= psel && penable && !pready_q;
            if (psel && penable && !pready_q)
            begin
                case (paddr)
                    ata_pkg::REG_STAT: prdata_q <= {last_q, 14'h0000, link.intrq, state_q != H_IDLE};
                    ata_pkg::REG_FILL: prdata_q <= {16'h0000, fill_q};
                    default: prdata_q <= 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fill_q <= 16'h0000;
        else if (apb_wr && paddr == ata_pkg::REG_FILL)
            fill_q <= pwdata[15:0];
    end

    // ************************************************************
    // Link sequencer
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= H_IDLE;
            req_data_q <= 16'h0000;
            req_addr_q <= 3'h0;
            req_rd_q <= 1'b0;
            fmt_q <= 1'b0;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            addr_q <= 3'h0;
            wdata_q <= 16'h0000;
            last_q <= 16'h0000;
            cnt_q <= 16'h0000;
        end
        else
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            case (state_q)
                H_IDLE:
                begin
                    if (apb_wr && paddr == ata_pkg::REG_REQ)
                    begin
                        req_data_q <= pwdata[15:0];
                        req_addr_q <= pwdata[ata_pkg::REQ_ADDR_LSB +: 3];
                        req_rd_q <= pwdata[ata_pkg::REQ_RD_BIT];
                        fmt_q <= 1'b0;
                        state_q <= (pwdata[ata_pkg::REQ_ADDR_LSB +: 3] == ata_pkg::TF_STATCMD
                            && !pwdata[ata_pkg::REQ_RD_BIT]) ? H_POLL : H_ISSUE;
                    end
                end
                H_POLL:
                begin
                    rd_q <= 1'b1;
                    addr_q <= ata_pkg::TF_STATCMD;
                    state_q <= H_RDWAIT;
                end
                H_RDWAIT:
                    state_q <= H_CHK;
                H_CHK:
                begin
                    if (!cmd_ok)
                        state_q <= H_POLL;
                    else if (fmt_q)
                    begin
                        cnt_q <= 16'h0000;
                        state_q <= H_FILL;
                    end
                    else
                        state_q <= H_ISSUE;
                end
                H_ISSUE:
                begin
                    addr_q <= req_addr_q;
                    wdata_q <= req_data_q;
                    if (req_rd_q)
                    begin
                        rd_q <= 1'b1;
                        req_rd_q <= 1'b0;
                        state_q <= H_FILL;
                        cnt_q <= 16'(ata_pkg::SECTOR_WORDS);
                    end
                    else
                    begin
                        wr_q <= 1'b1;
                        // Format is followed by one sector of fill words
                        fmt_q <= req_addr_q == ata_pkg::TF_STATCMD && req_data_q[7:0] == ata_pkg::CMD_FORMAT;
                        state_q <= (req_addr_q == ata_pkg::TF_STATCMD
                            && req_data_q[7:0] == ata_pkg::CMD_FORMAT) ? H_POLL : H_IDLE;
                    end
                end
                H_FILL:
                begin
                    if (cnt_q >= 16'(ata_pkg::SECTOR_WORDS))
                    begin
                        // Read data stands only one edge after the card samples rd
                        cnt_q <= cnt_q + 16'h0001;
                        if (cnt_q != 16'(ata_pkg::SECTOR_WORDS))
                        begin
                            state_q <= H_IDLE;
                            last_q <= link.rdata;
                        end
                    end
                    else
                    begin
                        wr_q <= 1'b1;
                        addr_q <= ata_pkg::TF_DATA;
                        wdata_q <= fill_q;
                        cnt_q <= cnt_q + 16'h0001;
                        if (cnt_q == 16'(ata_pkg::SECTOR_WORDS - 1))
                            state_q <= H_IDLE;
                    end
                end
                default: state_q <= H_IDLE;
            endcase
            if (state_q == H_CHK)
                last_q <= link.rdata;
        end
    end

    assign link.wr = wr_q;
    assign link.rd = rd_q;
    assign link.addr = addr_q;
    assign link.wdata = wdata_q;
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = 1'b0;
endmodule

// ==== tb/ata_link_chk.sv ====
// Assertions on the task-file link between host controller and card
`timescale 1ns/100ps
module ata_link_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr,
    input wire logic rd,
    input wire logic [2:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic intrq
);
    logic [7:0] cmd_q;
    logic [8:0] words_q;
    logic rd_q;
    logic busy_q;
    wire cmd_wr = wr && addr == 3'h7;
    // Last command, data words since it, busy flag of the last status read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmd_q <= 8'h00;
            words_q <= 9'h000;
            rd_q <= 1'b0;
            busy_q <= 1'b0;
        end
        else
        begin
            cmd_q <= cmd_wr ? wdata[7:0] : cmd_q;
            words_q <= cmd_wr ? 9'h000 : words_q + 9'(wr && addr == 3'h0);
            rd_q <= rd && addr == 3'h7;
            busy_q <= rd_q ? rdata[7] : busy_q;
        end
    end
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_bsy_clear: assert property (cmd_wr |-> !busy_q) else $error("command while busy");
    a_ready_idle: assert property (rd_q && !rdata[7] |-> rdata[6] && rdata[4]) else $error("idle not ready");
    a_drq_format: assert property (rd_q && rdata[3] |-> cmd_q == ata_pkg::CMD_FORMAT) else $error("stray drq");
    a_drq_count: assert property (rd_q && rdata[3] |-> words_q < 9'h100) else $error("drq after sector");
    a_data_format: assert property (wr && addr == 3'h0 |-> cmd_q == ata_pkg::CMD_FORMAT) else $error("data moved");
    a_intrq_clear: assert property ($fell(intrq) |-> $past(rd && addr == 3'h7)) else $error("intrq lost");
    a_rdata_hold: assert property ($past(rd) || $stable(rdata)) else $error("read data moved");
    a_strobe_excl: assert property (!(wr && rd)) else $error("both strobes");
endmodule

// ==== tb/ata_maintenance_commands_bench.sv ====
// Bench joining the card and the host controller over the task-file link
`timescale 1ns/100ps
module ata_maintenance_commands_bench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, look = 0, req_q = 0, diag_req, media_req, pready;
    logic fixed_disk_mode = 0, own_drive = 0, secondary_fail = 0, diag_done = 0, media_ack = 0, media_fault = 0;
    logic [7:0] paddr = 8'h00, diag_code = 8'h01;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [27:0] media_lba, lba;
    logic [63:0] e;
    logic [63:0] q[$];
    ata_pkg::media_op_e media_op;
    int num_errors = 0, compares = 0, acks = 0, k, n;
    ata_link_if link ();
    ata_card_dev #(.PREP_CYCLES(4)) ata_card_dev_inst (.pclk, .presetn, .link(link), .fixed_disk_mode, .own_drive,
        .secondary_fail, .diag_req, .diag_done, .diag_code, .media_req, .media_op, .media_lba, .media_pattern(),
        .media_ack, .media_fault);
    ata_host_ctrl ata_host_ctrl_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr(), .link(link));
    ata_link_chk ata_link_chk_inst (.pclk, .presetn, .wr(link.wr), .rd(link.rd), .addr(link.addr),
        .wdata(link.wdata), .rdata(link.rdata), .intrq(link.intrq));
    initial forever #2.5 pclk = ~pclk;
    task stop_test();
    begin
        if (num_errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask
    task tmo(input bit c);
    begin
        num_errors += c;
        if (c)
            stop_test();
    end
    endtask
    task pop(input logic [31:0] g);
    begin
        e = q.pop_front();
        compares++;
        if ((g & e[63:32]) !== (e[31:0] & e[63:32]))
        begin
            num_errors++;
            $display("BAD %0t exp %h got %h", $time, e[31:0] & e[63:32], g & e[63:32]);
        end
    end
    endtask
    // Media side stalls at random; it never acks a sector twice in a row
    always @(posedge pclk)
    begin
        media_ack <= media_req && !media_ack && $urandom % 3 != 0;
        diag_done <= diag_req;
        if (look && psel && penable && pready === 1'b1)
            pop(prdata);
        if (media_req === 1'b1 && !req_q)
            pop({2'b0, media_op, media_lba});
        acks = (media_req === 1'b1 && !req_q) ? 0 : acks + media_ack;
        if (media_req === 1'b0 && req_q)
            pop(acks);
        req_q = media_req;
    end
    // Extra edge at the end keeps psel low, so no signal is assigned twice in a step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i = 0;
    begin
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1;
        do
            @(posedge pclk);
        while (pready !== 1'b1 && i++ < 99);
        rdat = prdata;
        psel <= 0;
        penable <= 0;
        tmo(i >= 99);
        @(posedge pclk);
    end
    endtask
    task automatic tf(input logic r, input logic [2:0] a, input logic [7:0] d);
        int i = 0;
    begin
        apb(1, ata_pkg::REG_REQ, {11'h0, r, 1'b0, a, 8'h00, d});
        do
            apb(0, ata_pkg::REG_STAT, 0);
        while (rdat[0] !== 1'b0 && i++ < 999);
        tmo(i >= 999);
    end
    endtask
    task automatic ex(input logic [7:0] a, input logic [31:0] v, m);
    begin
        q.push_back({m, v});
        look <= 1;
        apb(0, a, 0);
        look <= 0;
    end
    endtask
    task automatic et(input logic [2:0] a, input logic [7:0] v, m);
    begin
        tf(1, a, 0);
        ex(ata_pkg::REG_STAT, {8'h0, v, 16'h0}, {8'h0, m, 16'h0});
    end
    endtask
    task automatic cmd(input logic [7:0] c);
        int i = 0;
    begin
        tf(0, 7, c);
        do
            tf(1, 7, 0);
        while (rdat[23] !== 1'b0 && i++ < 999);
        tmo(i >= 999);
    end
    endtask
    task automatic ld(input logic [27:0] l, input logic [7:0] c, input logic m);
    begin
        tf(0, 3, l[7:0]);
        tf(0, 4, l[15:8]);
        tf(0, 5, l[23:16]);
        tf(0, 6, {1'b0, m, 2'b00, l[27:24]});
        tf(0, 2, c);
    end
    endtask
    initial
    begin
        k = $urandom(66);
        repeat (6) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        et(1, ata_pkg::ERROR_RST, 8'hff);
        et(7, ata_pkg::STATUS_RST, 8'hff);
        ex(8'h0c, 0, 32'hffffffff);
        lba = $urandom;
        apb(1, ata_pkg::REG_FILL, lba);
        ex(ata_pkg::REG_FILL, lba, 32'hffff);
        for (k = 0; k < 5; k++)
        begin
            lba = $urandom;
            n = k == 1 ? 256 : k > 2 ? (k == 3 ? ata_pkg::SECT_PER_TRACK : 256) : $urandom % 9 + 1;
            ld(lba, n[7:0] + 8'(k == 3), k != 3);
            media_fault <= k == 2;
            q.push_back({k < 3 ? 32'h3fffffff : 32'h3fffff00, 2'b0, k < 3 ? 2'h1 : 2'h3, lba});
            q.push_back({32'hffffffff, n});
            cmd(k < 3 ? ata_pkg::CMD_ERASE : ata_pkg::CMD_FORMAT);
            et(7, {2'b01, k == 2, 5'h10}, 8'hf8);
        end
        media_fault <= 0;
        q.push_back({32'h30000000, 2'b0, ata_pkg::OP_FLUSH, 28'h0});
        q.push_back({32'hffffffff, 32'h1});
        cmd(ata_pkg::CMD_FLUSH);
        et(7, 8'h50, 8'hff);
        et(1, 8'h00, 8'hff);
        cmd(8'hee);
        et(1, ata_pkg::ERR_ABRT, 8'hff);
        for (k = 1; k < 6; k++)
        begin
            diag_code <= k[7:0];
            tf(0, 6, 8'h00);
            tf(0, 7, ata_pkg::CMD_DIAG);
            et(1, k[7:0], 8'hff);
            ex(ata_pkg::REG_STAT, 2, 2);
        end
        diag_code <= 8'h02;
        tf(0, 6, 8'h10);
        cmd(ata_pkg::CMD_DIAG);
        et(1, 8'h05, 8'hff);
        fixed_disk_mode <= 1;
        secondary_fail <= 1;
        diag_code <= 8'h01;
        cmd(ata_pkg::CMD_DIAG);
        et(1, 8'h81, 8'hff);
        stop_test();
    end
endmodule
